//--- sim/dlwt_panel_model.sv
`default_nettype none
module dlwt_panel_model
#(
  parameter int ESC_DIV = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] mode,
  input wire logic lane_oe,
  output logic panel_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Mode 0 never answers, 1 answers and returns, 2 keeps the lane
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      panel_busy <= 1'b0;
      cnt <= 0;
    end
    else if (lane_oe)
    begin
      panel_busy <= 1'b0;
      cnt <= 0;
    end
    else
    begin
      cnt <= cnt + 1;
      if (cnt == 3 && mode != 2'h0)
        panel_busy <= 1'b1;
      if (mode == 2'h1 && cnt == 3 + 8 * 2 * ESC_DIV)
        panel_busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- sim/dlwt_top_sva.sv
`default_nettype none
module dlwt_top_sva
  import dlwt_pkg::*;
#(
  parameter int ESC_DIV = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic lane_p,
  input wire logic lane_n,
  input wire logic lane_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_ctrl;
  logic next_wr_ctrl;
  logic [7:0] n10;
  logic [7:0] next_n10;
  logic [7:0] n00;
  logic [7:0] next_n00;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Run lengths of the two driven steps of a swap
  always_comb
  begin
    next_wr_ctrl = hsel && htrans[1] && hready && hwrite && haddr[7:0] == ADDR_CTRL;
    next_n10 = (lane_oe && lane_p && !lane_n) ? n10 + 8'h01 : 8'h00;
    next_n00 = (lane_oe && !lane_p && !lane_n) ? n00 + 8'h01 : 8'h00;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ctrl <= 1'b0;
      n10 <= 8'h00;
      n00 <= 8'h00;
    end
    else
    begin
      wr_ctrl <= next_wr_ctrl;
      n10 <= next_n10;
      n00 <= next_n00;
    end
  end
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_hrdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
    else $error("hrdata changed outside read");
  chk_swap_start: assert property (
    wr_ctrl && hwdata[CTRL_SWAP_GO] && lane_oe && lane_p && lane_n |=> lane_oe && lane_p && !lane_n)
    else $error("swap did not start with LP10");
  chk_lp10_len: assert property (lane_oe && !lane_p && !lane_n && n10 != 8'h00 |-> n10 == 8'(ESC_DIV))
    else $error("LP10 step length wrong");
  chk_lp00_len: assert property (!lane_oe && n00 != 8'h00 |-> n00 == 8'(ESC_DIV))
    else $error("LP00 step length wrong");
  chk_release_lp00: assert property ($fell(lane_oe) |-> !$past(lane_p) && !$past(lane_n))
    else $error("lane released outside LP00");
  chk_reclaim_lp11: assert property ($rose(lane_oe) |-> lane_p && lane_n)
    else $error("lane reclaimed not at LP11");
endmodule
bind dlwt_top dlwt_top_sva #(.ESC_DIV(ESC_DIV)) dlwt_top_sva_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .lane_p(lane_p), .lane_n(lane_n), .lane_oe(lane_oe));
`default_nettype wire

//--- sim/dlwt_top_tb.sv
`default_nettype none
module dlwt_top_tb
  import dlwt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ESC = 2;
  localparam int HT = 1000;
  localparam int HS = 100;
  localparam int BPP = 3;
  localparam int LN = 4;
  localparam int XTRA = 10;
  localparam logic [7:0] RA [10] = '{8'h14, 8'h18, 8'h1C, 8'h20, 8'h0C, 8'h40, 8'h34, 8'h38, 8'h00, 8'h44};
  localparam logic [31:0] RV [10] = '{32'h501, 32'hE, 32'h2C5, 32'h20, 32'h13, 32'hE0000, 32'h0, 32'h0, 32'h0,
    32'h0};
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout, hresp, lane_p, lane_n, lane_oe, irq, panel_busy;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] mode;
  int n_errors;
  int total_checks;
  int cycles;
  dlwt_top #(.ESC_DIV(ESC)) dlwt_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .panel_busy(panel_busy), .lane_p(lane_p), .lane_n(lane_n),
    .lane_oe(lane_oe), .irq(irq));
  dlwt_panel_model #(.ESC_DIV(ESC)) dlwt_panel_model_i (.hclk(hclk), .hresetn(hresetn), .mode(mode),
    .lane_oe(lane_oe), .panel_busy(panel_busy));
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end
  task complete_run();
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wait_rdy(output logic [31:0] d);
    logic r;
    r = 1'b0;
    while (r !== 1'b1)
    begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    wait_rdy(rd);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task derive(input logic [31:0] ctrl, input int link);
    int n, px, win, lat, tx, rx;
    wr(ADDR_CTRL, ctrl);
    wr(ADDR_LINK, 32'(link));
    n = (link + 159) / 160;
    px = ctrl[CTRL_SYNC_EVENT] ? HT : HT - HS;
    win = (px * BPP + LN - 1) / LN;
    lat = ctrl[CTRL_CLK_LANE_LP] ? 17 * n + 12 : (15 * n + 1) / 2 + 4;
    if (ctrl[CTRL_OVERRIDE])
      lat = lat + XTRA;
    tx = win > lat ? win - lat : 0;
    rx = tx > 14 * n ? tx - 14 * n : 0;
    repeat (4) @(posedge hclk);
    rdchk(ADDR_WINDOW, 32'(win));
    rdchk(ADDR_LATENCY, {16'(lat), 8'h00, 8'(n)});
    rdchk(ADDR_TX_ALLOW, 32'(tx));
    rdchk(ADDR_RX_ALLOW, 32'(rx));
    wr(ADDR_HOLD_TO, 32'(rx));
    rdchk(ADDR_HOLD_TO, 32'(rx));
  endtask
  task swap(input logic [1:0] m, input logic [31:0] st, input logic ir);
    int k;
    mode <= m;
    wr(ADDR_CTRL, 32'h8);
    k = 0;
    rd = 32'h0;
    while (rd === 32'h0 && k < 200)
    begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end
    chk(rd, st);
    chk({31'h0, irq}, {31'h0, ir});
    wr(ADDR_IRQ_CLR, 32'h7);
    rdchk(ADDR_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    mode = 2'h0;
    n_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 10; i++)
      rdchk(RA[i], RV[i]);
    wr(ADDR_WINDOW, 32'hFFFF);
    rdchk(ADDR_WINDOW, 32'h0);
    wr(ADDR_MAX_RET, 32'h3F);
    rdchk(ADDR_MAX_RET, 32'h20);
    wr(ADDR_MAX_RET, 32'h1F);
    rdchk(ADDR_MAX_RET, 32'h1F);
    wr(ADDR_HTOTAL, 32'(HT));
    wr(ADDR_HSYNC, 32'(HS));
    wr(ADDR_FORMAT, 32'(LN * 16 + BPP));
    wr(ADDR_TA_PARAM, {16'(XTRA), 8'h03, 8'h02});
    rdchk(ADDR_TIMER, 32'h000E0000);
    for (int i = 0; i < 8; i++)
      derive(32'(i % 4 == 3 ? 6 : i % 4), i < 4 ? 481 : 321);
    wr(ADDR_CTRL, 32'h4);
    rdchk(ADDR_TIMER, 32'h000D0000);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_HOLD_TO, 32'd40);
    wr(ADDR_IRQ_EN, 32'h4);
    swap(2'h1, 32'h4, 1'b1);
    swap(2'h0, 32'h1, 1'b0);
    swap(2'h2, 32'h2, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire

//--- src/dlwt_ceil_div.sv
`default_nettype none
module dlwt_ceil_div
#(
  parameter int NW = 20,
  parameter int DW = 3
)
(
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic [NW-1:0] quo
);
  logic [NW:0] sum;
  logic [NW:0] den_w;

  if (DW > NW)
  begin : g_check
    $error("dlwt_ceil_div: divisor wider than dividend");
  end

  // Rounds the quotient up; a zero divisor yields zero
  always_comb
  begin
    den_w = (NW+1)'(den);
    sum = (NW+1)'({1'b0, num} + den_w - (NW+1)'(1));
    if (den == '0)
    begin
      quo = '0;
    end
    else
    begin
      quo = NW'(sum / den_w);
    end
  end
endmodule
`default_nettype wire

//--- src/dlwt_pkg.sv
`default_nettype none
package dlwt_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HTOTAL = 8'h04;
  localparam logic [7:0] ADDR_HSYNC = 8'h08;
  localparam logic [7:0] ADDR_FORMAT = 8'h0C;
  localparam logic [7:0] ADDR_LINK = 8'h10;
  localparam logic [7:0] ADDR_TA_PARAM = 8'h14;
  localparam logic [7:0] ADDR_TA_TO = 8'h18;
  localparam logic [7:0] ADDR_HOLD_TO = 8'h1C;
  localparam logic [7:0] ADDR_MAX_RET = 8'h20;
  localparam logic [7:0] ADDR_WINDOW = 8'h24;
  localparam logic [7:0] ADDR_LATENCY = 8'h28;
  localparam logic [7:0] ADDR_TX_ALLOW = 8'h2C;
  localparam logic [7:0] ADDR_RX_ALLOW = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h38;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h3C;
  localparam logic [7:0] ADDR_TIMER = 8'h40;
  // Control bit positions
  localparam int CTRL_SYNC_EVENT = 0;
  localparam int CTRL_CLK_LANE_LP = 1;
  localparam int CTRL_OVERRIDE = 2;
  localparam int CTRL_SWAP_GO = 3;
  // Status bit positions
  localparam int STAT_TA_TIMEOUT = 0;
  localparam int STAT_HOLD_TIMEOUT = 1;
  localparam int STAT_SWAP_DONE = 2;
  localparam int STAT_W = 3;
  // Link timing constants
  localparam logic [7:0] LINK_MHZ_PER_ESC = 8'hA0;
  localparam logic [15:0] LAT_LP_MUL = 16'h0011;
  localparam logic [15:0] LAT_LP_ADD = 16'h000C;
  localparam logic [15:0] LAT_HS_MUL2 = 16'h000F;
  localparam logic [15:0] LAT_HS_ADD = 16'h0004;
  localparam logic [7:0] TURNAROUND_SURE_INTERVAL_DEFAULT = 8'h01;
  localparam logic [7:0] TURNAROUND_GET_INTERVAL_DEFAULT = 8'h05;
  localparam logic [9:0] TA_FIXED_STEPS = 10'h008;
  localparam logic [9:0] TA_DEFAULT_TOTAL = TA_FIXED_STEPS + 10'(TURNAROUND_SURE_INTERVAL_DEFAULT) + 10'(TURNAROUND_GET_INTERVAL_DEFAULT);
  // Worst-case panel ownership in escape clocks
  localparam int ESC_BITS_CLOCKS = 2;
  localparam int OWN_ENTRY = 5;
  localparam int OWN_ENTRY_CMD = 8 * ESC_BITS_CLOCKS;
  localparam int OWN_READ_HDR = 64;
  localparam int OWN_READ_PYLD = 512;
  localparam int OWN_READ_CRC = 32;
  localparam int OWN_ACK_HDR = 64;
  localparam int OWN_MARK_STOP = 2;
  localparam logic [15:0] OWN_WORST = 16'(OWN_ENTRY + OWN_ENTRY_CMD + OWN_READ_HDR + OWN_READ_PYLD
    + OWN_READ_CRC + OWN_ACK_HDR + OWN_MARK_STOP) + 16'(TA_DEFAULT_TOTAL);
  localparam logic [5:0] MAX_RETURN_LIMIT = 6'h20;
  // Escape clocks the host drives before the panel may answer
  localparam logic [15:0] TA_DRIVEN_STEPS = 16'h0002;
  // Lane levels {p, n}
  localparam logic [1:0] LP11 = 2'h3;
  localparam logic [1:0] LP10 = 2'h2;
  localparam logic [1:0] LP00 = 2'h0;

  typedef struct packed {
    logic sync_event;
    logic clk_lane_lp;
    logic ta_override;
    logic [15:0] htotal;
    logic [15:0] hsync_width;
    logic [2:0] bytes_per_pixel;
    logic [2:0] lanes;
    logic [11:0] link_mhz;
    logic [7:0] turnaround_sure_interval;
    logic [7:0] turnaround_get_interval;
    logic [15:0] latency_extra;
    logic [15:0] turnaround_timeout_value;
    logic [15:0] lp_receive_hold_timeout;
    logic [5:0] max_return_size;
  } dlwt_cfg_type;

  localparam dlwt_cfg_type CFG_RESET = '{
    sync_event: 1'b0, clk_lane_lp: 1'b0, ta_override: 1'b0,
    htotal: 16'h0000, hsync_width: 16'h0000, bytes_per_pixel: 3'h3, lanes: 3'h1,
    link_mhz: 12'h000, turnaround_sure_interval: TURNAROUND_SURE_INTERVAL_DEFAULT,
    turnaround_get_interval: TURNAROUND_GET_INTERVAL_DEFAULT, latency_extra: 16'h0000,
    turnaround_timeout_value: 16'(TA_DEFAULT_TOTAL), lp_receive_hold_timeout: OWN_WORST,
    max_return_size: MAX_RETURN_LIMIT};

  typedef enum logic [1:0] {DLWT_IDLE, DLWT_TURN, DLWT_HOLD} dlwt_state_type;
endpackage
`default_nettype wire

//--- src/dlwt_top.sv
// How it works
// RL1 - Window: total minus sync, or total
// RL2 - Pixels to bytes: ceiling size*bpp over lanes
// RL3 - Latency 17N+12 clock-lane LP, else 7.5N+4
// RL4 - N is ceiling of link MHz over 160
// RL5 - Tx/Rx allowed: window minus latency, timeout
// RL6 - Timeout in escape clocks, times N
// RL7 - Software sets hold timeout to Rx allowed
// RL8 - Software sizes return packet to fit Rx
// RL9 - Both timers bound panel link ownership
// RL10 - Swap steps total 14 escape clocks default
// RL11 - Sure/get default 1 and 5, override 8+sum
// RL12 - Threshold step counts one whole escape clock
// RL13 - Worst-case panel ownership is 709 escape clocks
// RL14 - Escape bits take two escape clocks each
// RL15 - Read payload per swap limited to 32
// RL16 - Overridden timing adds to the latency
// RL17 - Expired timer reclaims link, flags timeout
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`default_nettype none
module dlwt_top
  import dlwt_pkg::*;
#(
  parameter int ESC_DIV = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic panel_busy,
  output logic lane_p,
  output logic lane_n,
  output logic lane_oe,
  output logic irq
);
  localparam int EW = $clog2(ESC_DIV + 1);

  if (ESC_DIV < 1)
  begin : g_check
    $error("dlwt_top: ESC_DIV must be at least 1");
  end

  dlwt_cfg_type cfg, next_cfg;
  logic wr_pend, next_wr_pend;
  logic rd_pend, next_rd_pend;
  logic rd_ready, next_rd_ready;
  logic [7:0] addr_q, next_addr_q;
  logic [31:0] next_hrdata;
  logic [31:0] rd_mux;
  logic [STAT_W-1:0] status, next_status;
  logic [STAT_W-1:0] irq_en, next_irq_en;
  logic [STAT_W-1:0] clr_bits;
  logic [STAT_W-1:0] events;
  logic next_irq;
  logic swap_go;
  logic accept;

  logic [15:0] window_px;
  logic [19:0] window_num;
  logic [19:0] window_q;
  logic [11:0] n_q;
  logic [19:0] window_bytes, next_window_bytes;
  logic [7:0] esc_ratio, next_esc_ratio;
  logic [15:0] latency, next_latency;
  logic [23:0] tx_allow, next_tx_allow;
  logic [23:0] rx_allow, next_rx_allow;
  logic [9:0] swap_total, next_swap_total;
  logic [15:0] lat_base;
  logic [23:0] ta_to_bytes;

  logic busy_meta, busy_sync;
  logic [EW-1:0] esc_cnt, next_esc_cnt;
  logic esc_tick;
  dlwt_state_type state, next_state;
  logic [15:0] ta_count, next_ta_count;
  logic [15:0] hold_count, next_hold_count;
  logic [1:0] next_lane;
  logic next_lane_oe;

  assign accept = hsel && htrans[1] && hready;
  assign hreadyout = !(rd_pend && !rd_ready);
  assign hresp = 1'b0;

  // Register writes and bus phase tracking
  always_comb
  begin
    next_cfg = cfg;
    next_irq_en = irq_en;
    clr_bits = '0;
    swap_go = 1'b0;
    next_addr_q = accept ? haddr[7:0] : addr_q;
    next_wr_pend = accept && hwrite;
    next_rd_pend = accept ? !hwrite : (rd_ready ? 1'b0 : rd_pend);
    next_rd_ready = rd_pend && !rd_ready;
    next_hrdata = (rd_pend && !rd_ready) ? rd_mux : hrdata;
    if (wr_pend)
    begin
      unique case (addr_q)
        ADDR_CTRL:
        begin
          next_cfg.sync_event = hwdata[CTRL_SYNC_EVENT];
          next_cfg.clk_lane_lp = hwdata[CTRL_CLK_LANE_LP];
          next_cfg.ta_override = hwdata[CTRL_OVERRIDE];
          swap_go = hwdata[CTRL_SWAP_GO];
        end
        ADDR_HTOTAL: next_cfg.htotal = hwdata[15:0];
        ADDR_HSYNC: next_cfg.hsync_width = hwdata[15:0];
        ADDR_FORMAT:
        begin
          next_cfg.bytes_per_pixel = hwdata[2:0];
          next_cfg.lanes = hwdata[6:4];
        end
        ADDR_LINK: next_cfg.link_mhz = hwdata[11:0];
        ADDR_TA_PARAM:
        begin
          next_cfg.turnaround_sure_interval = hwdata[7:0];
          next_cfg.turnaround_get_interval = hwdata[15:8];
          next_cfg.latency_extra = hwdata[31:16];
        end
        ADDR_TA_TO: next_cfg.turnaround_timeout_value = hwdata[15:0];
        ADDR_HOLD_TO: next_cfg.lp_receive_hold_timeout = hwdata[15:0];
        ADDR_MAX_RET:
        begin
          if (hwdata > 32'(MAX_RETURN_LIMIT))
          begin
            next_cfg.max_return_size = MAX_RETURN_LIMIT; // [RL15]
          end
          else
          begin
            next_cfg.max_return_size = hwdata[5:0];
          end
        end
        ADDR_IRQ_EN: next_irq_en = hwdata[STAT_W-1:0];
        ADDR_IRQ_CLR: clr_bits = hwdata[STAT_W-1:0];
        default:
        begin
        end
      endcase
    end
  end

  // Read data selection; unmapped and write-only offsets read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (addr_q)
      ADDR_CTRL: rd_mux = 32'({cfg.ta_override, cfg.clk_lane_lp, cfg.sync_event});
      ADDR_HTOTAL: rd_mux = 32'(cfg.htotal);
      ADDR_HSYNC: rd_mux = 32'(cfg.hsync_width);
      ADDR_FORMAT: rd_mux = 32'({cfg.lanes, 1'b0, cfg.bytes_per_pixel});
      ADDR_LINK: rd_mux = 32'(cfg.link_mhz);
      ADDR_TA_PARAM: rd_mux = {cfg.latency_extra, cfg.turnaround_get_interval, cfg.turnaround_sure_interval};
      ADDR_TA_TO: rd_mux = 32'(cfg.turnaround_timeout_value);
      ADDR_HOLD_TO: rd_mux = 32'(cfg.lp_receive_hold_timeout);
      ADDR_MAX_RET: rd_mux = 32'(cfg.max_return_size);
      ADDR_WINDOW: rd_mux = 32'(window_bytes);
      ADDR_LATENCY: rd_mux = {latency, 8'h00, esc_ratio};
      ADDR_TX_ALLOW: rd_mux = 32'(tx_allow);
      ADDR_RX_ALLOW: rd_mux = 32'(rx_allow);
      ADDR_STATUS: rd_mux = 32'(status);
      ADDR_IRQ_EN: rd_mux = 32'(irq_en);
      ADDR_TIMER: rd_mux = {6'h00, swap_total, 14'h0000, state};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg <= CFG_RESET; // [RL13] [RL14]
      irq_en <= '0;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      rd_ready <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      cfg <= next_cfg;
      irq_en <= next_irq_en;
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      rd_ready <= next_rd_ready;
      addr_q <= next_addr_q;
      hrdata <= next_hrdata;
    end
  end

  // Window and ratio dividers
  always_comb
  begin
    if (cfg.sync_event || cfg.hsync_width > cfg.htotal)
    begin
      window_px = cfg.sync_event ? cfg.htotal : 16'h0000; // [RL1]
    end
    else
    begin
      window_px = cfg.htotal - cfg.hsync_width; // [RL1]
    end
    window_num = 20'(window_px) * 20'(cfg.bytes_per_pixel);
  end

  dlwt_ceil_div #(.NW(20), .DW(3)) u_window_div ( // [RL2]
    .num(window_num),
    .den(cfg.lanes),
    .quo(window_q)
  );

  dlwt_ceil_div #(.NW(12), .DW(8)) u_ratio_div ( // [RL4]
    .num(cfg.link_mhz),
    .den(LINK_MHZ_PER_ESC),
    .quo(n_q)
  );

  // Latency and allowed durations
  always_comb
  begin
    next_window_bytes = window_q;
    next_esc_ratio = n_q[7:0];
    if (cfg.clk_lane_lp)
    begin
      lat_base = 16'(esc_ratio) * LAT_LP_MUL + LAT_LP_ADD; // [RL3]
    end
    else
    begin
      lat_base = 16'((16'(esc_ratio) * LAT_HS_MUL2 + 16'h0001) >> 1) + LAT_HS_ADD; // [RL3]
    end
    next_latency = cfg.ta_override ? 16'(lat_base + cfg.latency_extra) : lat_base; // [RL16]
    ta_to_bytes = 24'(cfg.turnaround_timeout_value) * 24'(esc_ratio); // [RL6]
    if (24'(window_bytes) > 24'(latency))
    begin
      next_tx_allow = 24'(window_bytes) - 24'(latency); // [RL5]
    end
    else
    begin
      next_tx_allow = 24'h000000;
    end
    next_rx_allow = (tx_allow > ta_to_bytes) ? tx_allow - ta_to_bytes : 24'h000000; // [RL5]
    if (cfg.ta_override)
    begin
      next_swap_total = TA_FIXED_STEPS + 10'(cfg.turnaround_sure_interval) // [RL11]
        + 10'(cfg.turnaround_get_interval);
    end
    else
    begin
      next_swap_total = TA_DEFAULT_TOTAL; // [RL10] [RL11]
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      window_bytes <= 20'h00000;
      esc_ratio <= 8'h00;
      latency <= 16'h0000;
      tx_allow <= 24'h000000;
      rx_allow <= 24'h000000;
      swap_total <= TA_DEFAULT_TOTAL;
    end
    else
    begin
      window_bytes <= next_window_bytes;
      esc_ratio <= next_esc_ratio;
      latency <= next_latency;
      tx_allow <= next_tx_allow;
      rx_allow <= next_rx_allow;
      swap_total <= next_swap_total;
    end
  end

  // Panel ownership pin synchroniser
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_meta <= 1'b0;
      busy_sync <= 1'b0;
    end
    else
    begin
      busy_meta <= panel_busy;
      busy_sync <= busy_meta;
    end
  end

  // Bus direction swap timers
  always_comb
  begin
    next_esc_cnt = esc_cnt;
    esc_tick = 1'b0;
    if (state == DLWT_IDLE)
    begin
      next_esc_cnt = '0;
    end
    else if (esc_cnt == EW'(ESC_DIV - 1))
    begin
      next_esc_cnt = '0;
      esc_tick = 1'b1;
    end
    else
    begin
      next_esc_cnt = EW'(esc_cnt + EW'(1));
    end
    next_state = state;
    next_ta_count = ta_count;
    next_hold_count = hold_count;
    events = '0;
    unique case (state)
      DLWT_IDLE:
      begin
        if (swap_go)
        begin
          next_state = DLWT_TURN;
          next_ta_count = 16'h0000;
        end
      end
      DLWT_TURN:
      begin
        // Threshold crossing is resolved only at whole escape clocks
        if (esc_tick)
        begin
          next_ta_count = 16'(ta_count + 16'h0001); // [RL12] [RL6]
        end
        if (busy_sync && ta_count >= TA_DRIVEN_STEPS)
        begin
          next_state = DLWT_HOLD;
          next_hold_count = 16'h0000;
        end
        else if (esc_tick && 16'(ta_count + 16'h0001) >= cfg.turnaround_timeout_value)
        begin
          next_state = DLWT_IDLE; // [RL9] [RL17]
          events[STAT_TA_TIMEOUT] = 1'b1; // [RL17]
        end
      end
      DLWT_HOLD:
      begin
        next_hold_count = 16'(hold_count + 16'h0001);
        if (!busy_sync)
        begin
          next_state = DLWT_IDLE;
          events[STAT_SWAP_DONE] = 1'b1;
        end
        else if (next_hold_count >= cfg.lp_receive_hold_timeout)
        begin
          next_state = DLWT_IDLE; // [RL9] [RL17]
          events[STAT_HOLD_TIMEOUT] = 1'b1; // [RL17]
        end
      end
    endcase
    // Host drives LP10 then LP00, then releases the lane to the panel
    next_lane = LP11;
    next_lane_oe = 1'b1;
    if (next_state == DLWT_TURN)
    begin
      if (next_ta_count == 16'h0000)
      begin
        next_lane = LP10; // [RL10]
      end
      else if (next_ta_count == 16'h0001)
      begin
        next_lane = LP00; // [RL10]
      end
      else
      begin
        next_lane = LP00;
        next_lane_oe = 1'b0;
      end
    end
    else if (next_state == DLWT_HOLD)
    begin
      next_lane = LP00;
      next_lane_oe = 1'b0;
    end
    // New events win over a software clear in the same cycle
    next_status = (status & ~clr_bits) | events;
    next_irq = |(next_status & irq_en);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      esc_cnt <= '0;
      state <= DLWT_IDLE;
      ta_count <= 16'h0000;
      hold_count <= 16'h0000;
      lane_p <= LP11[1];
      lane_n <= LP11[0];
      lane_oe <= 1'b1;
      status <= '0;
      irq <= 1'b0;
    end
    else
    begin
      esc_cnt <= next_esc_cnt;
      state <= next_state;
      ta_count <= next_ta_count;
      hold_count <= next_hold_count;
      lane_p <= next_lane[1];
      lane_n <= next_lane[0];
      lane_oe <= next_lane_oe;
      status <= next_status;
      irq <= next_irq;
    end
  end
endmodule
`default_nettype wire
